// ===== inc/nsam_pkg.sv
package nsam_pkg;
  // fixed geometry of the namespace and controller tables
  localparam int NUM_NS = 8;
  localparam int NUM_CTRL = 4;
  localparam logic [15:0] OWN_CTRL = 16'h0000;
  // data structure: 4096 bytes as 1024 words
  localparam int BUF_WORDS = 1024;
  localparam logic [10:0] LIST_MAX = 11'h7ff;
  // register byte offsets
  localparam logic [15:0] OFS_CMD = 16'h0000;
  localparam logic [15:0] OFS_CDW10 = 16'h0004;
  localparam logic [15:0] OFS_NAMESPACE_IDENTIFIER = 16'h0008;
  localparam logic [15:0] OFS_PTR1_LO = 16'h000c;
  localparam logic [15:0] OFS_PTR1_HI = 16'h0010;
  localparam logic [15:0] OFS_PTR2_LO = 16'h0014;
  localparam logic [15:0] OFS_PTR2_HI = 16'h0018;
  localparam logic [15:0] OFS_CFG = 16'h001c;
  localparam logic [15:0] OFS_STATUS = 16'h0020;
  localparam logic [15:0] OFS_CPL_DW0 = 16'h0024;
  localparam logic [15:0] OFS_ERR_INFO = 16'h0028;
  localparam logic [15:0] OFS_ATT_MAP = 16'h002c;
  localparam logic [15:0] OFS_ALLOC_MAP = 16'h0030;
  localparam logic [15:0] OFS_BUF_BASE = 16'h1000;
  // field positions
  localparam int CMD_GO_BIT = 0;
  localparam int CMD_KIND_BIT = 1;
  localparam int CMD_WIPE_BIT = 2;
  localparam int CFG_NOTICE_BIT = 0;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_DONE_BIT = 1;
  localparam int ST_CODE_LSB = 8;
  localparam int SHARING_CAPABILITIES_SHARED_BIT = 0;
  // selector encodings, dword ten bits 3:0
  localparam logic [3:0] SEL_ATTACH = 4'h0;
  localparam logic [3:0] SEL_DETACH = 4'h1;
  localparam logic [3:0] SEL_CREATE = 4'h0;
  localparam logic [3:0] SEL_DELETE = 4'h1;
  localparam logic [31:0] NAMESPACE_IDENTIFIER_ALL = 32'hffffffff;
  // completion status codes
  localparam logic [7:0] SC_OK = 8'h00;
  localparam logic [7:0] SC_INV_FIELD = 8'h02;
  localparam logic [7:0] SC_INV_NS = 8'h0b;
  localparam logic [7:0] SC_NAMESPACE_IDENTIFIER_UNAVAIL = 8'h16;
  localparam logic [7:0] SC_ALREADY = 8'h18;
  localparam logic [7:0] SC_PRIVATE = 8'h19;
  localparam logic [7:0] SC_NOT_ATTACHED = 8'h1a;
  localparam logic [7:0] SC_LIST_INVALID = 8'h1c;
  // reset values
  localparam logic [31:0] RST_WORD = 32'h00000000;

  typedef enum logic {NSAM_KIND_ATTACH = 1'b0, NSAM_KIND_MANAGE = 1'b1} nsam_kind_t;

  typedef struct packed {
    nsam_kind_t kind;
    logic [3:0] select;
    logic [31:0] namespace_identifier;
  } nsam_cmd_t;

  typedef struct packed {
    logic [7:0] status;
    logic [31:0] dw0;
    logic [11:0] err_pos;
  } nsam_cpl_t;

  typedef struct packed {
    logic [63:0] namespace_size;
    logic [63:0] namespace_capacity;
    logic [7:0] formatted_block_size;
    logic [7:0] protection_type_settings;
    logic [7:0] sharing_capabilities;
  } nsam_attr_t;
endpackage

// ===== hdl/nsam_buf.sv
`timescale 1ns/1ps
// holds the 4096-byte data structure; one write port, one registered read port
module nsam_buf (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [9:0] wr_addr,
  input wire logic [31:0] wr_data,
  input wire logic [9:0] rd_addr,
  output logic [31:0] rd_data
);
  logic [31:0] mem [0:nsam_pkg::BUF_WORDS-1];

  // whole structure word-addressed, no reset so it maps to block ram
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // read data lags the address by one edge
  always_ff @(posedge clk) begin
    rd_data <= mem[rd_addr];
  end
endmodule

// ===== hdl/nsam_top.sv
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
// Operation
// - attach and detach results persist across every reset
// - attach and detach use a 4096-byte controller list structure
// - attachment selector 0h attaches, 1h detaches, 2h-Fh reserved
// - every finished attachment command posts one completion with status
// - failures record byte position of the first failing entry
// - processing of the list stops at the first error
// - status 18h already attached, 19h private namespace already attached
// - status 1Ah detach of unattached controller, 1Ch invalid list
// - io submission queues keep running during management operations
// - create leaves the new namespace unattached
// - delete detaches the namespace from every controller
// - delete of namespace attached elsewhere raises that controller's notice
// - successful create leaves the namespace formatted with host attributes
// - delete transfers no data structure
// - create ignores host identifier; device picks a free one
// - delete names its namespace; all-ones deletes every namespace
// - create structure: bytes 383:0 fields, reserved, vendor specific
module nsam_top (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [15:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic ADMIN_BUSY,
  output logic [nsam_pkg::NUM_CTRL-1:0] ATTR_NOTICE
);
  localparam int NS = nsam_pkg::NUM_NS;
  localparam int NC = nsam_pkg::NUM_CTRL;
  localparam int OWN_CTRL_IDX = int'(nsam_pkg::OWN_CTRL);

  typedef enum logic [7:0] {
    NSAM_IDLE = 8'h01,
    NSAM_DISPATCH = 8'h02,
    NSAM_HDR_WAIT = 8'h04,
    NSAM_HDR = 8'h08,
    NSAM_ENT_WAIT = 8'h10,
    NSAM_ENT = 8'h20,
    NSAM_CR_WAIT = 8'h40,
    NSAM_DONE = 8'h80
  } nsam_state_t;

  nsam_state_t state;
  nsam_pkg::nsam_cmd_t cmd_reg;
  nsam_pkg::nsam_cmd_t cmd;
  nsam_pkg::nsam_cpl_t res;
  nsam_pkg::nsam_cpl_t cpl;
  nsam_pkg::nsam_attr_t attr [0:NS-1];
  nsam_pkg::nsam_attr_t new_attr;
  logic [63:0] ptr1;
  logic [63:0] ptr2;
  logic notice_en;
  logic done_flag;
  logic [NC-1:0] att_map [0:NS-1];
  logic [NS-1:0] alloc;
  logic [10:0] count;
  logic [10:0] idx;
  logic [2:0] cr_word;
  logic [9:0] rd_addr;
  logic [31:0] rd_data;
  logic [2:0] slot;
  logic [2:0] free_slot;
  logic free_any;
  logic [NS*NC-1:0] att_flat;

  // apb decode: zero wait states, errors on unmapped addresses
  logic apb_wr;
  logic apb_rd;
  logic in_buf;
  logic mapped;
  logic go;
  logic wipe;
  logic buf_wr;
  assign apb_wr = PSEL && PENABLE && PWRITE;
  assign apb_rd = PSEL && PENABLE && !PWRITE;
  assign in_buf = PADDR[15:12] == nsam_pkg::OFS_BUF_BASE[15:12];
  assign go = apb_wr && PADDR == nsam_pkg::OFS_CMD && PWDATA[nsam_pkg::CMD_GO_BIT];
  assign wipe = apb_wr && PADDR == nsam_pkg::OFS_CMD && PWDATA[nsam_pkg::CMD_WIPE_BIT];
  // the buffer may only be rewritten while no command is reading it
  assign buf_wr = apb_wr && in_buf && state == NSAM_IDLE;
  assign PREADY = 1'b1;
  assign ADMIN_BUSY = state != NSAM_IDLE;

  // flat views of the tables for register reads
  genvar gn;
  generate
    for (gn = 0; gn < NS; gn++) begin : g_flat
      assign att_flat[gn*NC +: NC] = att_map[gn];
    end
  endgenerate

  // lowest unallocated slot; the identifier handed out is slot plus one
  always_comb begin
    free_slot = 3'h0;
    free_any = 1'b0;
    for (int i = NS - 1; i >= 0; i--) begin
      if (!alloc[i]) begin
        free_slot = 3'(i);
        free_any = 1'b1;
      end
    end
  end

  // create fields gathered out of the first eight words of the structure
  logic [63:0] cr_size;
  logic [63:0] cr_cap;
  logic [31:0] cr_w6;
  logic [31:0] cr_w7;
  always_comb begin
    new_attr.namespace_size = cr_size;
    new_attr.namespace_capacity = cr_cap;
    new_attr.formatted_block_size = cr_w6[23:16];
    new_attr.protection_type_settings = cr_w7[15:8];
    new_attr.sharing_capabilities = cr_w7[23:16];
  end

  // current list entry: byte 2+2*idx, high half of the word when idx is even
  logic [11:0] ent_pos;
  logic [10:0] ent_nxt;
  logic [15:0] ent_id;
  logic ent_bad;
  logic ent_att;
  logic ent_others;
  logic ns_ok;
  assign ent_pos = {idx, 1'b0} + 12'h002;
  assign ent_nxt = idx + 11'h001;
  assign ent_id = idx[0] ? rd_data[15:0] : rd_data[31:16];
  assign ent_bad = ent_id >= 16'(NC);
  assign ent_att = !ent_bad && att_map[slot][ent_id[1:0]];
  assign ent_others = |(att_map[slot] & ~(NC'(1) << ent_id[1:0]));
  assign ns_ok = cmd.namespace_identifier != 32'h0 && cmd.namespace_identifier <= 32'(NS) && alloc[cmd.namespace_identifier[2:0] - 3'h1];

  // apb-writable command and configuration registers
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      cmd_reg <= '0;
      ptr1 <= '0;
      ptr2 <= '0;
      notice_en <= 1'b0;
    end else if (apb_wr) begin
      unique case (PADDR)
        nsam_pkg::OFS_CMD: cmd_reg.kind <= nsam_pkg::nsam_kind_t'(PWDATA[nsam_pkg::CMD_KIND_BIT]);
        nsam_pkg::OFS_CDW10: cmd_reg.select <= PWDATA[3:0];
        nsam_pkg::OFS_NAMESPACE_IDENTIFIER: cmd_reg.namespace_identifier <= PWDATA;
        nsam_pkg::OFS_PTR1_LO: ptr1[31:0] <= PWDATA;
        nsam_pkg::OFS_PTR1_HI: ptr1[63:32] <= PWDATA;
        // only kept for software; the buffer never spans a pointer list
        nsam_pkg::OFS_PTR2_LO: ptr2[31:0] <= PWDATA;
        nsam_pkg::OFS_PTR2_HI: ptr2[63:32] <= PWDATA;
        nsam_pkg::OFS_CFG: notice_en <= PWDATA[nsam_pkg::CFG_NOTICE_BIT];
        default: ;
      endcase
    end
  end

  // completion flag: a new completion wins over a clear in the same cycle
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      done_flag <= 1'b0;
      cpl <= '0;
    end else if (state == NSAM_DONE) begin
      done_flag <= 1'b1;
      cpl <= res;
    end else if (apb_wr && PADDR == nsam_pkg::OFS_STATUS && PWDATA[nsam_pkg::ST_DONE_BIT]) begin
      done_flag <= 1'b0;
    end
  end

  // read mux and slave error
  always_comb begin
    PRDATA = nsam_pkg::RST_WORD;
    mapped = 1'b1;
    unique case (PADDR)
      nsam_pkg::OFS_CMD: PRDATA = {30'h0, cmd_reg.kind, 1'b0};
      nsam_pkg::OFS_CDW10: PRDATA = {28'h0, cmd_reg.select};
      nsam_pkg::OFS_NAMESPACE_IDENTIFIER: PRDATA = cmd_reg.namespace_identifier;
      nsam_pkg::OFS_PTR1_LO: PRDATA = ptr1[31:0];
      nsam_pkg::OFS_PTR1_HI: PRDATA = ptr1[63:32];
      nsam_pkg::OFS_PTR2_LO: PRDATA = ptr2[31:0];
      nsam_pkg::OFS_PTR2_HI: PRDATA = ptr2[63:32];
      nsam_pkg::OFS_CFG: PRDATA = {31'h0, notice_en};
      nsam_pkg::OFS_STATUS: PRDATA = {16'h0, cpl.status, 6'h0, done_flag, ADMIN_BUSY};
      nsam_pkg::OFS_CPL_DW0: PRDATA = cpl.dw0;
      nsam_pkg::OFS_ERR_INFO: PRDATA = {20'h0, cpl.err_pos};
      nsam_pkg::OFS_ATT_MAP: PRDATA = att_flat;
      nsam_pkg::OFS_ALLOC_MAP: PRDATA = {24'h0, alloc};
      default: mapped = in_buf; // buffer is write-only, reads as zero
    endcase
  end
  assign PSLVERR = PSEL && PENABLE && !mapped;

  nsam_buf u_buf (
    .clk(MCLK),
    .wr_en(buf_wr),
    .wr_addr(PADDR[11:2]),
    .wr_data(PWDATA),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  // command sequencer
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      state <= NSAM_IDLE;
      cmd <= '0;
      res <= '0;
      count <= '0;
      idx <= '0;
      cr_word <= '0;
      rd_addr <= '0;
      slot <= '0;
    end else begin
      unique case (state)
        NSAM_IDLE: begin
          if (go) begin
            // kind rides in the same write as go, so take it from the bus
            cmd.kind <= nsam_pkg::nsam_kind_t'(PWDATA[nsam_pkg::CMD_KIND_BIT]);
            cmd.select <= cmd_reg.select;
            cmd.namespace_identifier <= cmd_reg.namespace_identifier;
            res <= '0;
            state <= NSAM_DISPATCH;
          end
        end
        NSAM_DISPATCH: begin
          slot <= cmd.namespace_identifier[2:0] - 3'h1;
          rd_addr <= '0;
          if (cmd.select > nsam_pkg::SEL_DETACH) begin
            res.status <= nsam_pkg::SC_INV_FIELD;
            state <= NSAM_DONE;
          end else if (cmd.kind == nsam_pkg::NSAM_KIND_ATTACH) begin
            if (ns_ok) begin
              state <= NSAM_HDR_WAIT;
            end else begin
              res.status <= nsam_pkg::SC_INV_NS;
              state <= NSAM_DONE;
            end
          end else if (cmd.select == nsam_pkg::SEL_CREATE) begin
            // the identifier field from the host plays no part in create
            if (free_any) begin
              slot <= free_slot;
              cr_word <= '0;
              state <= NSAM_CR_WAIT;
            end else begin
              res.status <= nsam_pkg::SC_NAMESPACE_IDENTIFIER_UNAVAIL;
              state <= NSAM_DONE;
            end
          end else begin
            // delete works on the tables alone, nothing is fetched
            if (cmd.namespace_identifier != nsam_pkg::NAMESPACE_IDENTIFIER_ALL && !ns_ok) begin
              res.status <= nsam_pkg::SC_INV_NS;
            end
            state <= NSAM_DONE;
          end
        end
        NSAM_HDR_WAIT: state <= NSAM_HDR;
        NSAM_HDR: begin
          count <= rd_data[10:0];
          idx <= '0;
          if (rd_data[15:0] == 16'h0 || rd_data[15:0] > 16'(nsam_pkg::LIST_MAX)) begin
            res.status <= nsam_pkg::SC_LIST_INVALID;
            state <= NSAM_DONE;
          end else begin
            rd_addr <= 10'h000;
            state <= NSAM_ENT_WAIT;
          end
        end
        NSAM_ENT_WAIT: state <= NSAM_ENT;
        NSAM_ENT: begin
          idx <= ent_nxt;
          rd_addr <= ent_nxt[10:1] + {9'h0, ent_nxt[0]};
          if (ent_bad || cmd.select == nsam_pkg::SEL_ATTACH && ent_att ||
              cmd.select == nsam_pkg::SEL_ATTACH && ent_others &&
              !attr[slot].sharing_capabilities[nsam_pkg::SHARING_CAPABILITIES_SHARED_BIT] ||
              cmd.select == nsam_pkg::SEL_DETACH && !ent_att) begin
            res.err_pos <= ent_pos;
            state <= NSAM_DONE;
          end else if (ent_nxt == count) begin
            state <= NSAM_DONE;
          end else begin
            // the next entry's word needs one edge to come out of the buffer
            state <= NSAM_ENT_WAIT;
          end
          if (ent_bad) begin
            res.status <= nsam_pkg::SC_LIST_INVALID;
          end else if (cmd.select == nsam_pkg::SEL_ATTACH && ent_att) begin
            res.status <= nsam_pkg::SC_ALREADY;
          end else if (cmd.select == nsam_pkg::SEL_ATTACH && ent_others &&
                       !attr[slot].sharing_capabilities[nsam_pkg::SHARING_CAPABILITIES_SHARED_BIT]) begin
            res.status <= nsam_pkg::SC_PRIVATE;
          end else if (cmd.select == nsam_pkg::SEL_DETACH && !ent_att) begin
            res.status <= nsam_pkg::SC_NOT_ATTACHED;
          end
        end
        NSAM_CR_WAIT: begin
          // words 0..7 cover bytes 31:0 of the identify fields
          rd_addr <= 10'(cr_word) + 10'h001;
          cr_word <= cr_word + 3'h1;
          if (rd_addr == 10'h008) begin
            res.dw0 <= 32'(slot) + 32'h1;
            state <= NSAM_DONE;
          end
        end
        NSAM_DONE: state <= NSAM_IDLE;
        default: state <= NSAM_IDLE;
      endcase
    end
  end

  // capture create words as they stream out of the buffer
  logic cr_valid;
  logic [2:0] cr_idx;
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      cr_valid <= 1'b0;
      cr_idx <= '0;
      cr_size <= '0;
      cr_cap <= '0;
      cr_w6 <= '0;
      cr_w7 <= '0;
    end else begin
      cr_valid <= state == NSAM_CR_WAIT && rd_addr < 10'h008;
      cr_idx <= rd_addr[2:0];
      if (cr_valid) begin
        unique case (cr_idx)
          3'h0: cr_size[31:0] <= rd_data;
          3'h1: cr_size[63:32] <= rd_data;
          3'h2: cr_cap[31:0] <= rd_data;
          3'h3: cr_cap[63:32] <= rd_data;
          3'h6: cr_w6 <= rd_data;
          3'h7: cr_w7 <= rd_data;
          default: ; // reserved bytes are not looked at
        endcase
      end
    end
  end

  // commit pulses: one per accepted list entry, create and delete out of the done cycle
  logic ent_commit;
  logic cr_commit;
  logic del_commit;
  assign ent_commit = state == NSAM_ENT && res.status == nsam_pkg::SC_OK && !ent_bad &&
                      (cmd.select == nsam_pkg::SEL_ATTACH ? !ent_att &&
                       (!ent_others || attr[slot].sharing_capabilities[nsam_pkg::SHARING_CAPABILITIES_SHARED_BIT])
                       : ent_att);
  assign cr_commit = state == NSAM_DONE && cmd.kind == nsam_pkg::NSAM_KIND_MANAGE &&
                     cmd.select == nsam_pkg::SEL_CREATE && res.status == nsam_pkg::SC_OK;
  assign del_commit = state == NSAM_DONE && cmd.kind == nsam_pkg::NSAM_KIND_MANAGE &&
                      cmd.select == nsam_pkg::SEL_DELETE && res.status == nsam_pkg::SC_OK;

  // persistent tables: left out of reset on purpose so outcomes survive it; alloc and att_map are
  // cleared by an explicit wipe from software, and row by row by a delete; attr is only overwritten by a create
  always_ff @(posedge MCLK) begin
    if (wipe && state == NSAM_IDLE) begin
      alloc <= '0;
      for (int n = 0; n < NS; n++) begin
        att_map[n] <= '0;
      end
    end else if (ent_commit) begin
      att_map[slot][ent_id[1:0]] <= cmd.select == nsam_pkg::SEL_ATTACH;
    end else if (cr_commit) begin
      alloc[slot] <= 1'b1;
      att_map[slot] <= '0;
      attr[slot] <= new_attr;
    end else if (del_commit) begin
      for (int n = 0; n < NS; n++) begin
        if (cmd.namespace_identifier == nsam_pkg::NAMESPACE_IDENTIFIER_ALL || n == 32'(slot)) begin
          alloc[n] <= 1'b0;
          att_map[n] <= '0;
        end
      end
    end
  end

  // a delete tells every other controller still attached about the change
  logic [NC-1:0] del_rows;
  always_comb begin
    del_rows = '0;
    for (int n = 0; n < NS; n++) begin
      if (cmd.namespace_identifier == nsam_pkg::NAMESPACE_IDENTIFIER_ALL || n == 32'(slot)) begin
        del_rows = del_rows | att_map[n];
      end
    end
  end
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      ATTR_NOTICE <= '0;
    end else if (del_commit && notice_en) begin
      ATTR_NOTICE <= del_rows & ~(NC'(1) << OWN_CTRL_IDX);
    end else begin
      ATTR_NOTICE <= '0;
    end
  end

  // reserved selector reaches the completion two edges after dispatch
  a_reserved_sel_field: assert property (@(posedge MCLK) disable iff (!RST_N)
    state == NSAM_DISPATCH && cmd.select > nsam_pkg::SEL_DETACH
    |-> ##2 done_flag && cpl.status == nsam_pkg::SC_INV_FIELD)
    else $error("reserved selector not rejected");

  a_done_posts_once: assert property (@(posedge MCLK) disable iff (!RST_N)
    state == NSAM_DONE |=> done_flag && state == NSAM_IDLE && cpl == $past(res))
    else $error("completion not posted");

  a_list_err_stop: assert property (@(posedge MCLK) disable iff (!RST_N)
    state == NSAM_ENT && ent_bad |=> state == NSAM_DONE && res.err_pos == $past(ent_pos))
    else $error("list kept running after error");

  a_already_attached: assert property (@(posedge MCLK) disable iff (!RST_N)
    state == NSAM_ENT && !ent_bad && cmd.select == nsam_pkg::SEL_ATTACH && ent_att
    |=> res.status == nsam_pkg::SC_ALREADY)
    else $error("already attached status missing");

  a_detach_missing: assert property (@(posedge MCLK) disable iff (!RST_N)
    state == NSAM_ENT && !ent_bad && cmd.select == nsam_pkg::SEL_DETACH && !ent_att
    |=> res.status == nsam_pkg::SC_NOT_ATTACHED)
    else $error("not attached status missing");

  a_delete_no_fetch: assert property (@(posedge MCLK) disable iff (!RST_N)
    state == NSAM_DISPATCH && cmd.kind == nsam_pkg::NSAM_KIND_MANAGE &&
    cmd.select == nsam_pkg::SEL_DELETE |=> state == NSAM_DONE)
    else $error("delete touched the buffer");

  a_create_unattached: assert property (@(posedge MCLK) disable iff (!RST_N)
    cr_commit && !wipe |=> alloc[$past(slot)] && att_map[$past(slot)] == '0)
    else $error("created namespace attached");

  a_delete_detach: assert property (@(posedge MCLK) disable iff (!RST_N)
    del_commit && cmd.namespace_identifier != nsam_pkg::NAMESPACE_IDENTIFIER_ALL
    |=> !alloc[$past(slot)] && att_map[$past(slot)] == '0)
    else $error("deleted namespace still attached");

  a_notice_cause: assert property (@(posedge MCLK) disable iff (!RST_N)
    ATTR_NOTICE != '0 |-> $past(del_commit) && $past(notice_en) ##1 ATTR_NOTICE == '0)
    else $error("notice without delete");
endmodule

// ===== sim/nsam_host.sv
`timescale 1ns/1ps
// apb master standing in for host software; one transfer at a time
module nsam_host (
  input wire logic clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [15:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // bus idle from time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0000;
    pwdata = 32'h00000000;
  end

  // setup cycle, access until pready, then release
  task automatic xfer(input logic wr, input logic [15:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released lines flip so no one can lean on stale values
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

// ===== sim/tb_nsam_top.sv
`timescale 1ns/1ps
module tb_nsam_top;
  logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, busy;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, q, st;
  logic [3:0] notice, seen;
  logic e;
  int mismatches = 0;
  int n_tests = 0;

  nsam_top uut (.MCLK(mclk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .ADMIN_BUSY(busy), .ATTR_NOTICE(notice));
  nsam_host host (.clk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // notice bits are one-cycle pulses, so collect them
  always @(posedge mclk) begin
    seen <= seen | notice;
  end

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      mismatches++;
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [15:0] a);
    host.xfer(1'b0, a, 32'h00000000, q, e);
  endtask

  // controller list: count, then up to two 16-bit ids
  task automatic lst(input logic [15:0] n, input logic [15:0] a, input logic [15:0] b);
    wr(nsam_pkg::OFS_BUF_BASE, {a, n});
    wr(nsam_pkg::OFS_BUF_BASE + 16'h0004, {16'h0000, b});
  endtask

  // create structure; reserved words written as zero
  task automatic mk(input logic [7:0] sh);
    logic [31:0] w[8];
    w = '{32'h100, 0, 32'h80, 0, 0, 0, {8'h00, 8'h02, 16'h0000}, {8'h00, sh, 8'h01, 8'h00}};
    for (int i = 0; i < 8; i++) begin
      wr(nsam_pkg::OFS_BUF_BASE + 16'(4 * i), w[i]);
    end
  endtask

  // issue one command and wait, bounded, for done
  task automatic cmd(input logic k, input logic [3:0] s, input logic [31:0] id);
    wr(nsam_pkg::OFS_CDW10, {28'h0000000, s});
    wr(nsam_pkg::OFS_NAMESPACE_IDENTIFIER, id);
    wr(nsam_pkg::OFS_CMD, {30'h00000000, k, 1'b1});
    // busy must be up in the cycle after go is taken
    @(negedge mclk);
    chk("busy", 32'h1, {31'h0, busy});
    for (int i = 0; i < 40; i++) begin
      rd(nsam_pkg::OFS_STATUS);
      if (q[nsam_pkg::ST_DONE_BIT] === 1'b1) begin
        break;
      end
    end
    st = q;
    chk("idle", 32'h0, {31'h0, st[nsam_pkg::ST_BUSY_BIT]});
    chk("done", 32'h1, {31'h0, st[nsam_pkg::ST_DONE_BIT]});
    wr(nsam_pkg::OFS_STATUS, 32'h00000002);
  endtask

  task automatic code(input logic [7:0] c);
    chk("status", {24'h0, c}, {24'h0, st[15:8]});
  endtask

  task automatic map(input logic [15:0] a, input logic [31:0] v);
    rd(a);
    chk("map", v, q);
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    wrap_up();
  end

  initial begin
    rst_n = 1'b0;
    seen = 4'h0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    wr(nsam_pkg::OFS_CMD, 32'h00000004);
    wr(nsam_pkg::OFS_PTR2_LO, 32'h00002000);
    map(nsam_pkg::OFS_PTR2_LO, 32'h00002000);
    cmd(1'b0, 4'h2, 32'h1); code(nsam_pkg::SC_INV_FIELD);
    cmd(1'b1, 4'hf, 32'h0); code(nsam_pkg::SC_INV_FIELD);
    map(nsam_pkg::OFS_ALLOC_MAP, 32'h0);
    mk(8'h01);
    cmd(1'b1, nsam_pkg::SEL_CREATE, 32'h0); code(nsam_pkg::SC_OK);
    map(nsam_pkg::OFS_CPL_DW0, 32'h1);
    map(nsam_pkg::OFS_ALLOC_MAP, 32'h1);
    map(nsam_pkg::OFS_ATT_MAP, 32'h0);
    lst(16'h2, 16'h0, 16'h1);
    cmd(1'b0, nsam_pkg::SEL_ATTACH, 32'h1); code(nsam_pkg::SC_OK);
    map(nsam_pkg::OFS_ATT_MAP, 32'h3);
    lst(16'h1, 16'h0, 16'h0);
    cmd(1'b0, nsam_pkg::SEL_ATTACH, 32'h1); code(nsam_pkg::SC_ALREADY);
    map(nsam_pkg::OFS_ERR_INFO, 32'h2);
    lst(16'h1, 16'h3, 16'h0);
    cmd(1'b0, nsam_pkg::SEL_DETACH, 32'h1); code(nsam_pkg::SC_NOT_ATTACHED);
    lst(16'h0, 16'h0, 16'h0);
    cmd(1'b0, nsam_pkg::SEL_DETACH, 32'h1); code(nsam_pkg::SC_LIST_INVALID);
    // private namespace: second entry fails, first one stays attached
    mk(8'h00);
    cmd(1'b1, nsam_pkg::SEL_CREATE, 32'h0); code(nsam_pkg::SC_OK);
    map(nsam_pkg::OFS_CPL_DW0, 32'h2);
    lst(16'h3, 16'h0, 16'h1);
    cmd(1'b0, nsam_pkg::SEL_ATTACH, 32'h2); code(nsam_pkg::SC_PRIVATE);
    map(nsam_pkg::OFS_ERR_INFO, 32'h4);
    map(nsam_pkg::OFS_ATT_MAP, 32'h13);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    map(nsam_pkg::OFS_ATT_MAP, 32'h13);
    wr(nsam_pkg::OFS_CFG, 32'h00000001);
    // cleared off the rising edge so the collector cannot undo it
    @(negedge mclk);
    seen = 4'h0;
    cmd(1'b1, nsam_pkg::SEL_DELETE, 32'h1); code(nsam_pkg::SC_OK);
    chk("notice", 32'h2, {28'h0, seen});
    map(nsam_pkg::OFS_ATT_MAP, 32'h10);
    map(nsam_pkg::OFS_ALLOC_MAP, 32'h2);
    // detach first, as hosts are advised to; only controller 0 was attached and the delete never notifies it
    lst(16'h1, 16'h0, 16'h0);
    cmd(1'b0, nsam_pkg::SEL_DETACH, 32'h2); code(nsam_pkg::SC_OK);
    @(negedge mclk);
    seen = 4'h0;
    cmd(1'b1, nsam_pkg::SEL_DELETE, nsam_pkg::NAMESPACE_IDENTIFIER_ALL); code(nsam_pkg::SC_OK);
    chk("notice", 32'h0, {28'h0, seen});
    map(nsam_pkg::OFS_ALLOC_MAP, 32'h0);
    map(nsam_pkg::OFS_ATT_MAP, 32'h0);
    rd(16'h0040);
    chk("slverr", 32'h1, {31'h0, e});
    wrap_up();
  end
endmodule
